// ---- rtl/lpi_pkg.sv ----
`default_nettype none
package lpi_pkg;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [3:0] ADDR_INTERRUPT_CONTROL = 4'h2;
	localparam logic [3:0] ADDR_PROX_LOW = 4'h3;
	localparam logic [3:0] ADDR_PROX_HIGH = 4'h4;
	localparam logic [3:0] ADDR_LIGHT_TH_LO = 4'h5;
	localparam logic [3:0] ADDR_LIGHT_TH_MID = 4'h6;
	localparam logic [3:0] ADDR_LIGHT_TH_HI = 4'h7;
	localparam logic [3:0] ADDR_PROX_RESULT = 4'h8;
	localparam logic [3:0] ADDR_LIGHT_RES_LOW = 4'h9;
	localparam logic [3:0] ADDR_LIGHT_RES_HIGH = 4'ha;
	localparam logic [3:0] ADDR_TEST_MODE_A = 4'he;
	localparam logic [3:0] ADDR_TEST_MODE_B = 4'hf;
	// ----------------------------------------
	// interrupt control fields
	// ----------------------------------------
	localparam int PROX_FLAG_BIT = 7;
	localparam int PROX_PERS_HI = 6;
	localparam int PROX_PERS_LO = 5;
	localparam int UNUSED_BIT = 4;
	localparam int LIGHT_FLAG_BIT = 3;
	localparam int LIGHT_PERS_HI = 2;
	localparam int LIGHT_PERS_LO = 1;
	localparam int COMBINE_BIT = 0;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h00;
	localparam logic [7:0] RST_PROX_LOW = 8'h00;
	localparam logic [7:0] RST_PROX_HIGH = 8'hff;
	localparam logic [7:0] RST_LIGHT_TH_LO = 8'h00;
	localparam logic [7:0] RST_LIGHT_TH_MID = 8'hf0;
	localparam logic [7:0] RST_LIGHT_TH_HI = 8'hff;
	localparam logic [7:0] RST_RESULT = 8'h00;
	localparam logic [7:0] RST_TEST = 8'h00;
	// ----------------------------------------
	// persistence counts
	// ----------------------------------------
	localparam logic [4:0] PERS_CNT_0 = 5'h01;
	localparam logic [4:0] PERS_CNT_1 = 5'h04;
	localparam logic [4:0] PERS_CNT_2 = 5'h08;
	localparam logic [4:0] PERS_CNT_3 = 5'h10;
	localparam logic [4:0] CNT_ZERO = 5'h00;
endpackage
`default_nettype wire

// ---- rtl/lpi_persist.sv ----
`timescale 1ns/1ps
`default_nettype none
module lpi_persist (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic sample,
	input wire logic outside,
	input wire logic [1:0] pers_sel,
	output logic trip
);
	logic [4:0] cnt_reg;
	logic [4:0] cnt_next;
	logic [4:0] need;
	logic reached;

	// ----------------------------------------
	// persistence decode
	// ----------------------------------------
	// code to count map
	assign need = (pers_sel == 2'b00) ? lpi_pkg::PERS_CNT_0 :
		(pers_sel == 2'b01) ? lpi_pkg::PERS_CNT_1 :
		(pers_sel == 2'b10) ? lpi_pkg::PERS_CNT_2 : lpi_pkg::PERS_CNT_3;
	assign reached = (cnt_reg + 5'h01) >= need;
	assign cnt_next = !sample ? cnt_reg :
		!outside ? lpi_pkg::CNT_ZERO :
		reached ? cnt_reg : cnt_reg + 5'h01;
	assign trip = sample && outside && reached;

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_reg <= lpi_pkg::CNT_ZERO;
		end else if (ce) begin
			cnt_reg <= cnt_next;
		end
	end
endmodule
`default_nettype wire

// ---- rtl/lpi_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - proximity flag bit 7 sticky, write-0 clears
// - proximity flag zero after reset or clear
// - light flag bit 3 sticky, write-0 clears
// - light flag zero after reset or clear
// - proximity persistence 1/4/8/16 from bits 6:5
// - light persistence 1/4/8/16 from bits 2:1
// - combine 0: pin low on either flag
// - combine 1: pin low on both flags
// - proximity low threshold, reset zero
// - proximity high threshold, reset all ones
// - light low threshold from lo and mid[3:0]
// - light high threshold from mid[7:4], hi
// - proximity result read-only, reset zero
// - light result split, upper nibble reads zero
// - test registers reset zero, normal when zero
// - outside window conversion counts as tripping
// - consecutive independent persistence counters
module lpi_regs (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic CE,
	input wire logic [3:0] ADDR,
	input wire logic WR_EN,
	input wire logic [7:0] WR_DATA,
	input wire logic RD_EN,
	output logic [7:0] RD_DATA,
	input wire logic PROX_VALID,
	input wire logic [7:0] PROX_DATA_IN,
	input wire logic LIGHT_VALID,
	input wire logic [11:0] LIGHT_DATA_IN,
	output logic INT_N,
	output logic TEST_ACTIVE
);
	logic [7:0] ctrl_reg;
	logic [7:0] prox_lo_reg;
	logic [7:0] prox_hi_reg;
	logic [7:0] lt_lo_reg;
	logic [7:0] lt_mid_reg;
	logic [7:0] lt_hi_reg;
	logic [7:0] prox_res_reg;
	logic [11:0] light_res_reg;
	logic [7:0] test_a_reg;
	logic [7:0] test_b_reg;
	logic [7:0] rd_next;
	logic [7:0] ctrl_next;
	logic prox_flag_next;
	logic light_flag_next;
	logic int_n_next;
	logic [4:0] prox_run_reg;
	logic [4:0] light_run_reg;
	wire wr = WR_EN && CE;
	wire wr_ctrl = wr && (ADDR == lpi_pkg::ADDR_INTERRUPT_CONTROL);
	wire [11:0] light_low_threshold;
	wire [11:0] light_high_threshold;
	wire prox_outside;
	wire light_outside;
	wire prox_trip;
	wire light_trip;
	wire prox_flag = ctrl_reg[lpi_pkg::PROX_FLAG_BIT];
	wire light_flag = ctrl_reg[lpi_pkg::LIGHT_FLAG_BIT];

	// ----------------------------------------
	// window comparison
	// ----------------------------------------
	function automatic logic out_of_window(input logic [11:0] v, input logic [11:0] lo,
		input logic [11:0] hi);
		out_of_window = (v < lo) || (v > hi);
	endfunction

	assign light_low_threshold = {lt_mid_reg[3:0], lt_lo_reg};
	assign light_high_threshold = {lt_hi_reg, lt_mid_reg[7:4]};
	assign prox_outside = out_of_window({4'h0, PROX_DATA_IN}, {4'h0, prox_lo_reg},
		{4'h0, prox_hi_reg});
	assign light_outside = out_of_window(LIGHT_DATA_IN, light_low_threshold,
		light_high_threshold);

	// ----------------------------------------
	// persistence counters
	// ----------------------------------------
	// proximity persistence counter
	lpi_persist u_prox_pers (
		.clk(CORE_CLK),
		.rst(RST),
		.ce(CE),
		.sample(PROX_VALID),
		.outside(prox_outside),
		.pers_sel(ctrl_reg[lpi_pkg::PROX_PERS_HI:lpi_pkg::PROX_PERS_LO]),
		.trip(prox_trip)
	);
	lpi_persist u_light_pers (
		.clk(CORE_CLK),
		.rst(RST),
		.ce(CE),
		.sample(LIGHT_VALID),
		.outside(light_outside),
		.pers_sel(ctrl_reg[lpi_pkg::LIGHT_PERS_HI:lpi_pkg::LIGHT_PERS_LO]),
		.trip(light_trip)
	);

	// ----------------------------------------
	// flags and control
	// ----------------------------------------
	// set wins, write 0 clears, write 1 keeps
	assign prox_flag_next = prox_trip ||
		(prox_flag && !(wr_ctrl && !WR_DATA[lpi_pkg::PROX_FLAG_BIT]));
	// set wins, write 0 clears, write 1 keeps
	assign light_flag_next = light_trip ||
		(light_flag && !(wr_ctrl && !WR_DATA[lpi_pkg::LIGHT_FLAG_BIT]));
	assign ctrl_next = {prox_flag_next,
		wr_ctrl ? WR_DATA[6:4] : ctrl_reg[6:4],
		light_flag_next,
		wr_ctrl ? WR_DATA[2:0] : ctrl_reg[2:0]};
	assign int_n_next = ctrl_next[lpi_pkg::COMBINE_BIT] ?
		!(ctrl_next[lpi_pkg::PROX_FLAG_BIT] && ctrl_next[lpi_pkg::LIGHT_FLAG_BIT]) :
		!(ctrl_next[lpi_pkg::PROX_FLAG_BIT] || ctrl_next[lpi_pkg::LIGHT_FLAG_BIT]);

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	always_comb begin
		case (ADDR)
			lpi_pkg::ADDR_INTERRUPT_CONTROL: rd_next = ctrl_reg;
			lpi_pkg::ADDR_PROX_LOW: rd_next = prox_lo_reg;
			lpi_pkg::ADDR_PROX_HIGH: rd_next = prox_hi_reg;
			lpi_pkg::ADDR_LIGHT_TH_LO: rd_next = lt_lo_reg;
			lpi_pkg::ADDR_LIGHT_TH_MID: rd_next = lt_mid_reg;
			lpi_pkg::ADDR_LIGHT_TH_HI: rd_next = lt_hi_reg;
			lpi_pkg::ADDR_PROX_RESULT: rd_next = prox_res_reg;
			lpi_pkg::ADDR_LIGHT_RES_LOW: rd_next = light_res_reg[7:0];
			lpi_pkg::ADDR_LIGHT_RES_HIGH: rd_next = {4'h0, light_res_reg[11:8]};
			lpi_pkg::ADDR_TEST_MODE_A: rd_next = test_a_reg;
			lpi_pkg::ADDR_TEST_MODE_B: rd_next = test_b_reg;
			default: rd_next = 8'h00;
		endcase
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			ctrl_reg <= lpi_pkg::RST_INTERRUPT_CONTROL;
			INT_N <= 1'b1;
			RD_DATA <= 8'h00;
		end else if (CE) begin
			ctrl_reg <= ctrl_next;
			INT_N <= int_n_next;
			if (RD_EN) begin
				RD_DATA <= rd_next;
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			prox_lo_reg <= lpi_pkg::RST_PROX_LOW;
			prox_hi_reg <= lpi_pkg::RST_PROX_HIGH;
			lt_lo_reg <= lpi_pkg::RST_LIGHT_TH_LO;
			lt_mid_reg <= lpi_pkg::RST_LIGHT_TH_MID;
			lt_hi_reg <= lpi_pkg::RST_LIGHT_TH_HI;
			test_a_reg <= lpi_pkg::RST_TEST;
			test_b_reg <= lpi_pkg::RST_TEST;
		end else if (wr) begin
			case (ADDR)
				lpi_pkg::ADDR_PROX_LOW: prox_lo_reg <= WR_DATA;
				lpi_pkg::ADDR_PROX_HIGH: prox_hi_reg <= WR_DATA;
				lpi_pkg::ADDR_LIGHT_TH_LO: lt_lo_reg <= WR_DATA;
				lpi_pkg::ADDR_LIGHT_TH_MID: lt_mid_reg <= WR_DATA;
				lpi_pkg::ADDR_LIGHT_TH_HI: lt_hi_reg <= WR_DATA;
				lpi_pkg::ADDR_TEST_MODE_A: test_a_reg <= WR_DATA;
				lpi_pkg::ADDR_TEST_MODE_B: test_b_reg <= WR_DATA;
				default: ;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			prox_res_reg <= lpi_pkg::RST_RESULT;
			light_res_reg <= {4'h0, lpi_pkg::RST_RESULT};
			TEST_ACTIVE <= 1'b0;
		end else if (CE) begin
			if (PROX_VALID) begin
				prox_res_reg <= PROX_DATA_IN;
			end
			if (LIGHT_VALID) begin
				light_res_reg <= LIGHT_DATA_IN;
			end
			TEST_ACTIVE <= (test_a_reg != 8'h00) || (test_b_reg != 8'h00);
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_prox_flag_sticky: assert property (@(posedge CORE_CLK) disable iff (RST)
		(CE && prox_flag && !(wr_ctrl && !WR_DATA[7])) |=> prox_flag)
		else $error("proximity flag dropped without clear");
	a_prox_flag_clear: assert property (@(posedge CORE_CLK) disable iff (RST)
		(CE && wr_ctrl && !WR_DATA[7] && !prox_trip) |=> !prox_flag)
		else $error("proximity flag not cleared");
	a_light_flag_sticky: assert property (@(posedge CORE_CLK) disable iff (RST)
		(CE && light_flag && !(wr_ctrl && !WR_DATA[3])) |=> light_flag)
		else $error("light flag dropped without clear");
	a_light_flag_clear: assert property (@(posedge CORE_CLK) disable iff (RST)
		(CE && wr_ctrl && !WR_DATA[3] && !light_trip) |=> !light_flag)
		else $error("light flag not cleared");
	a_prox_single_trip: assert property (@(posedge CORE_CLK) disable iff (RST)
		(CE && PROX_VALID && prox_outside && ctrl_reg[6:5] == 2'b00) |=> prox_flag)
		else $error("single trip did not set proximity flag");
	a_light_single_trip: assert property (@(posedge CORE_CLK) disable iff (RST)
		(CE && LIGHT_VALID && light_outside && ctrl_reg[2:1] == 2'b00) |=> light_flag)
		else $error("single trip did not set light flag");
	a_int_or_mode: assert property (@(posedge CORE_CLK) disable iff (RST)
		(!ctrl_reg[0] && (prox_flag || light_flag)) |-> !INT_N)
		else $error("pin high with a flag set in or mode");
	a_int_and_mode: assert property (@(posedge CORE_CLK) disable iff (RST)
		(ctrl_reg[0] && !(prox_flag && light_flag)) |-> INT_N)
		else $error("pin low without both flags in and mode");
	a_inside_no_trip: assert property (@(posedge CORE_CLK) disable iff (RST)
		(PROX_VALID && PROX_DATA_IN >= prox_lo_reg && PROX_DATA_IN <= prox_hi_reg)
		|-> !prox_trip)
		else $error("inside conversion tripped");

	// ----------------------------------------
	// check helpers
	// ----------------------------------------
	function automatic logic [4:0] run_step(input logic [4:0] run, input logic outside);
		if (!outside) begin
			run_step = lpi_pkg::CNT_ZERO;
		end else if (run < lpi_pkg::PERS_CNT_3) begin
			run_step = run + 5'h01;
		end else begin
			run_step = run;
		end
	endfunction

	function automatic logic run_enough(input logic [4:0] run, input logic [1:0] code);
		case (code)
			2'h0: run_enough = 1'b1;
			2'h1: run_enough = (run + 5'h01) >= lpi_pkg::PERS_CNT_1;
			2'h2: run_enough = (run + 5'h01) >= lpi_pkg::PERS_CNT_2;
			default: run_enough = (run + 5'h01) >= lpi_pkg::PERS_CNT_3;
		endcase
	endfunction

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			prox_run_reg <= lpi_pkg::CNT_ZERO;
			light_run_reg <= lpi_pkg::CNT_ZERO;
		end else if (CE) begin
			if (PROX_VALID) begin
				prox_run_reg <= run_step(prox_run_reg, prox_outside);
			end
			if (LIGHT_VALID) begin
				light_run_reg <= run_step(light_run_reg, light_outside);
			end
		end
	end

	a_prox_persist_run: assert property (@(posedge CORE_CLK) disable iff (RST)
		(CE && prox_trip) |-> run_enough(prox_run_reg, ctrl_reg[6:5]))
		else $error("proximity trip before enough outside results");
	a_light_persist_run: assert property (@(posedge CORE_CLK) disable iff (RST)
		(CE && light_trip) |-> run_enough(light_run_reg, ctrl_reg[2:1]))
		else $error("light trip before enough outside results");
	a_prox_low_write: assert property (@(posedge CORE_CLK) disable iff (RST)
		(wr && ADDR == lpi_pkg::ADDR_PROX_LOW) |=> (prox_lo_reg == $past(WR_DATA)))
		else $error("proximity low threshold write lost");
	a_prox_high_write: assert property (@(posedge CORE_CLK) disable iff (RST)
		(wr && ADDR == lpi_pkg::ADDR_PROX_HIGH) |=> (prox_hi_reg == $past(WR_DATA)))
		else $error("proximity high threshold write lost");
	a_light_low_split: assert property (@(posedge CORE_CLK) disable iff (RST)
		(wr && ADDR == lpi_pkg::ADDR_LIGHT_TH_MID)
		|=> (light_low_threshold[11:8] == $past(WR_DATA[3:0])))
		else $error("light low threshold upper bits wrong");
	a_light_high_split: assert property (@(posedge CORE_CLK) disable iff (RST)
		(wr && ADDR == lpi_pkg::ADDR_LIGHT_TH_MID)
		|=> (light_high_threshold[3:0] == $past(WR_DATA[7:4])))
		else $error("light high threshold lower bits wrong");
	a_prox_result_load: assert property (@(posedge CORE_CLK) disable iff (RST)
		(CE && PROX_VALID) |=> (prox_res_reg == $past(PROX_DATA_IN)))
		else $error("proximity result not captured");
	a_light_high_nibble: assert property (@(posedge CORE_CLK) disable iff (RST)
		(CE && RD_EN && ADDR == lpi_pkg::ADDR_LIGHT_RES_HIGH) |=> (RD_DATA[7:4] == 4'h0))
		else $error("light result upper nibble not zero");
	a_test_zero_normal: assert property (@(posedge CORE_CLK) disable iff (RST)
		(CE && test_a_reg == lpi_pkg::RST_TEST && test_b_reg == lpi_pkg::RST_TEST)
		|=> !TEST_ACTIVE)
		else $error("test status high with zero test registers");
	a_prox_outside_seen: assert property (@(posedge CORE_CLK) disable iff (RST)
		(PROX_VALID && (PROX_DATA_IN < prox_lo_reg || PROX_DATA_IN > prox_hi_reg))
		|-> prox_outside)
		else $error("outside proximity result not seen");
	a_light_inside_no_trip: assert property (@(posedge CORE_CLK) disable iff (RST)
		(LIGHT_VALID && LIGHT_DATA_IN >= light_low_threshold
		&& LIGHT_DATA_IN <= light_high_threshold) |-> !light_trip)
		else $error("inside light conversion tripped");
endmodule
`default_nettype wire

// ---- bench/lpi_conv_src.sv ----
`timescale 1ns/1ps
`default_nettype none
module lpi_conv_src (
	input wire logic clk,
	output logic prox_valid,
	output logic [7:0] prox_data,
	output logic light_valid,
	output logic [11:0] light_data
);
	initial begin
		prox_valid = 1'b0;
		light_valid = 1'b0;
		prox_data = 8'h00;
		light_data = 12'h000;
	end
	// ----------------------------------------
	// one conversion result
	// ----------------------------------------
	task automatic send(input bit lt, input logic [11:0] v);
		@(negedge clk);
		if (lt) begin
			light_valid = 1'b1;
			light_data = v;
		end else begin
			prox_valid = 1'b1;
			prox_data = v[7:0];
		end
		@(negedge clk);
		prox_valid = 1'b0;
		light_valid = 1'b0;
		// stale data inverted once released
		prox_data = ~prox_data;
		light_data = ~light_data;
	endtask
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic [3:0] addr = 4'h0;
	logic wr_en = 1'b0;
	logic [7:0] wr_data = 8'h00;
	logic rd_en = 1'b0;
	logic [7:0] rd_data;
	logic prox_valid;
	logic [7:0] prox_data;
	logic light_valid;
	logic [11:0] light_data;
	logic int_n;
	logic test_active;
	int mismatches = 0;
	int checks = 0;
	int cycles = 0;
	logic [3:0] ra [13] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'he, 4'hf,
		4'h0, 4'hb};
	logic [7:0] rv [13] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'hf0, 8'hff, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00};
	always #5 clk = ~clk;
	lpi_regs i_dut (.CORE_CLK(clk), .RST(rst), .CE(ce), .ADDR(addr), .WR_EN(wr_en),
		.WR_DATA(wr_data), .RD_EN(rd_en), .RD_DATA(rd_data), .PROX_VALID(prox_valid),
		.PROX_DATA_IN(prox_data), .LIGHT_VALID(light_valid), .LIGHT_DATA_IN(light_data),
		.INT_N(int_n), .TEST_ACTIVE(test_active));
	lpi_conv_src i_src (.clk(clk), .prox_valid(prox_valid), .prox_data(prox_data),
		.light_valid(light_valid), .light_data(light_data));
	// ----------------------------------------
	// checking and closing
	// ----------------------------------------
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			report_and_stop();
		end
	end
	// ----------------------------------------
	// register access
	// ----------------------------------------
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wr_data = d;
		wr_en = 1'b1;
		@(negedge clk);
		wr_en = 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(negedge clk);
		addr = a;
		rd_en = 1'b1;
		@(negedge clk);
		rd_en = 1'b0;
		chk(rd_data, e);
	endtask
	task automatic int_chk(input logic e);
		chk({7'h00, int_n}, {7'h00, e});
	endtask
	// ----------------------------------------
	// persistence run for one code
	// ----------------------------------------
	task automatic pers(input bit lt, input logic [1:0] c);
		int n;
		logic [7:0] cv;
		logic [11:0] v;
		n = (c == 2'b00) ? 1 : (2 << c);
		cv = lt ? {5'h00, c, 1'b0} : {1'b0, c, 5'h00};
		wr(4'h2, cv);
		rd(4'h2, cv);
		for (int i = 0; i <= 2 * n; i++) begin
			if (i == 2 * n) rd(4'h2, cv);
			if (i == 0 || i == n) v = lt ? 12'h456 : 12'h080;
			else if (i % 2 == 1) v = lt ? 12'h122 : 12'h00f;
			else v = lt ? 12'h457 : 12'h081;
			i_src.send(lt, v);
		end
		@(negedge clk);
		rd(4'h2, cv | (lt ? 8'h08 : 8'h80));
		int_chk(1'b0);
		wr(4'h2, cv | (lt ? 8'h08 : 8'h80));
		rd(4'h2, cv | (lt ? 8'h08 : 8'h80));
		if (lt) begin
			rd(4'h9, 8'h57);
			rd(4'ha, 8'h04);
		end else begin
			rd(4'h8, 8'h81);
		end
	endtask
	initial begin
		repeat (16) @(negedge clk);
		rst = 1'b0;
		for (int i = 0; i < 13; i++) rd(ra[i], rv[i]);
		int_chk(1'b1);
		chk({7'h00, test_active}, 8'h00);
		$display("reset values done");
		for (int i = 3; i < 8; i++) begin
			wr(i[3:0], {i[3:0], ~i[3:0]});
			rd(i[3:0], {i[3:0], ~i[3:0]});
		end
		wr(4'h8, 8'h77);
		rd(4'h8, 8'h00);
		wr(4'he, 8'h00);
		rd(4'he, 8'h00);
		$display("access done");
		wr(4'h3, 8'h10);
		wr(4'h4, 8'h80);
		wr(4'h5, 8'h23);
		wr(4'h6, 8'h61);
		wr(4'h7, 8'h45);
		for (int k = 0; k < 8; k++) pers(k[2], k[1:0]);
		$display("persistence done");
		wr(4'h2, 8'h09);
		rd(4'h2, 8'h09);
		int_chk(1'b1);
		i_src.send(1'b0, 12'h0ff);
		@(negedge clk);
		rd(4'h2, 8'h89);
		int_chk(1'b0);
		wr(4'h2, 8'h81);
		rd(4'h2, 8'h81);
		int_chk(1'b1);
		wr(4'h2, 8'h80);
		rd(4'h2, 8'h80);
		int_chk(1'b0);
		wr(4'h2, 8'h08);
		rd(4'h2, 8'h00);
		int_chk(1'b1);
		$display("combine done");
		ce = 1'b0;
		wr(4'h3, 8'h55);
		i_src.send(1'b0, 12'h0fe);
		@(negedge clk);
		ce = 1'b1;
		rd(4'h3, 8'h10);
		rd(4'h8, 8'hff);
		rd(4'h2, 8'h00);
		int_chk(1'b1);
		i_src.send(1'b0, 12'h0ff);
		@(negedge clk);
		int_chk(1'b0);
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		rd(4'h4, 8'hff);
		rd(4'h2, 8'h00);
		int_chk(1'b1);
		$display("enable and reset done");
		report_and_stop();
	end
endmodule
`default_nettype wire
